// ===== bench/spt_rx_model.sv
// Purpose: receiver model that decodes the biphase line into subframes
// Assumes: smp marks one settled line state per half-bit cell
// Notes:   locks on three equal states after a toggle, which coded data never shows
`timescale 1ns/1ps
`default_nettype none
module spt_rx_model (
	input  wire logic  clk,
	input  wire logic  smp,
	input  wire logic  line,
	output logic       sf_stb,
	output logic [7:0] sf_pre,
	output logic [27:0] sf_bits,
	output logic       sf_err
);
	logic [3:0]  h;
	logic [7:0]  pre;
	logic [27:0] bits;
	logic        err;
	int          cnt;
	initial begin
		h = 4'h0;
		cnt = 1000;
		sf_stb = 1'b0;
	end
	always @(negedge clk) begin
		sf_stb <= 1'b0;
		if (smp) begin
			h = {h[2:0], line};
			cnt = cnt + 1;
			if (h[2:0] == {3{line}} && h[3] != line && cnt >= 8) begin
				cnt = 2;
				pre = 8'h80;
				bits = 28'h000_0000;
				err = 1'b0;
			end else if (cnt < 8) begin
				pre[7-cnt] = h[0] ^ h[1];
			end else if (cnt < 64) begin
				if (cnt[0])
					bits[cnt/2-4] = h[0] ^ h[1];
				else if (h[0] == h[1])
					err = 1'b1;
			end
			if (cnt == 63) begin
				sf_stb <= 1'b1;
				sf_pre <= pre;
				sf_bits <= bits;
				sf_err <= err;
			end
		end
	end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Purpose: self-checking bench of the pass-through transmitter
// Assumes: pll tick or pin clock every fourth clock with divider one, frame sync every 128 cells
// Notes:   data of the first frame after start-up is not compared, it may be stale
`timescale 1ns/1ps
`default_nettype none
module tb;
	import spt_pkg::*;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        alt_toggle, pll_bit_tick, tx_line, fs_sel, sf_stb, sf_err;
	logic [7:0]  paddr, sf_pre;
	logic [31:0] pwdata, prdata, cs;
	logic [127:0] rx0_slots;
	spt_pair_t   rx1_pair, alt_pair;
	logic [1:0]  fsp, ph;
	logic [8:0]  fcnt;
	logic [27:0] sf_bits;
	logic [36:0] q[$];
	int          n_mismatch, n_tests;

	spt_spdif_tx spt_spdif_tx_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx0_slots(rx0_slots), .rx1_pair(rx1_pair), .alt_pair(alt_pair),
		.alt_toggle(alt_toggle), .frame_sync_pins(fsp), .serial_clock_input_pin(ph[1]),
		.pll_bit_tick(pll_bit_tick), .tx_line(tx_line));
	spt_rx_model spt_rx_model_inst (.clk(clk), .smp(ph == 2'h3), .line(tx_line), .sf_stb(sf_stb),
		.sf_pre(sf_pre), .sf_bits(sf_bits), .sf_err(sf_err));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// bit clock of 128 cells per frame, from the pll tick or from the pin as ph[1]
	always @(posedge clk) begin
		ph <= ph + 2'h1;
		pll_bit_tick <= (ph == 2'h3);
		fcnt <= fcnt + 9'h001;
		fsp <= fs_sel ? {fcnt[8], 1'b0} : {1'b0, fcnt[8]};
	end
	always @(posedge clk)
		if (sf_stb)
			q.push_back({sf_err, sf_pre, sf_bits});

	task test_done;
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic er);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 1, k < 50);
	endtask
	task run_cfg(input int i);
		logic [31:0] r, s0, s1, m, t;
		logic [1:0]  ls, rs, res, ow, w;
		logic [10:0] c;
		logic [13:0] f;
		logic [26:0] b;
		logic [36:0] x;
		logic        e, den, mono, lo;
		int          src, k, j;
		ls = 2'(i % 4);
		rs = 2'(3 - i % 4);
		res = 2'(i % 4);
		ow = 2'(i / 4);
		src = i % 3;
		den = (i % 5 != 4);
		mono = i[3];
		k = $urandom;
		rx0_slots <= {$urandom, $urandom, $urandom, $urandom};
		rx1_pair <= {$urandom, $urandom};
		alt_pair <= {$urandom, $urandom};
		fs_sel <= i[0];
		// keep-alive bit is random and must not matter
		c = {mono, !i[2], i[1], i[0], src == 1, 1'b0, src == 2, 1'b0, k[0], den, 1'b1};
		apb(1'b1, OFS_CTRL, {21'h0, c}, r, e);
		alt_toggle <= ~alt_toggle;
		lo = 1'b1;
		// the line register takes one more edge to see the new power-down
		@(posedge clk);
		for (k = 0; k < 300; k++) begin
			@(posedge clk);
			lo = lo & (tx_line === 1'b0);
		end
		chk("line_low", 1, lo);
		f = {3'h0, 3'(i % 7), ow, res, rs, ls};
		apb(1'b1, OFS_FMT, {18'h0, f}, r, e);
		apb(1'b0, OFS_FMT, 32'h0000_0000, r, e);
		chk("fmt", {18'h0, f}, r);
		q.delete();
		apb(1'b1, OFS_CTRL, {21'h0, c[10:1], 1'b0}, r, e);
		k = 0;
		while (q.size() < 6 && k < 5000) begin
			@(posedge clk);
			k++;
		end
		chk("subframes", 1, q.size() >= 6);
		if (src == 2)
			{s0, s1} = alt_pair;
		else if (src == 1)
			{s0, s1} = rx1_pair;
		else begin
			s0 = rx0_slots[32*ls +: 32];
			s1 = rx0_slots[32*rs +: 32];
		end
		w = (res < ow) ? res : ow;
		m = (w == 2'h3) ? 32'hffff_ffff : (w == 2'h2) ? 32'hffff_ff00 : (w == 2'h1) ? 32'hffff_f000 : 32'hffff_0000;
		for (j = 0; j < 6 && q.size() >= 6; j++) begin
			x = q[j];
			chk("coding", 0, x[36]);
			chk("preamble", (j == 0) ? PRE_B : (j % 2) ? PRE_W : PRE_M, x[35:28]);
			// mono leaves the second subframe empty
			t = (mono && j % 2 == 1) ? 32'h0000_0000 : ((j % 2) ? s1 : s0) & m;
			b = {cs[j/2], 1'b0, !den || (mono && j % 2 == 1), den ? t[31:8] : 24'h00_0000};
			if (j >= 2)
				chk("slots", {^b, b}, x[27:0]);
		end
		// one long run reaches status bits 24..27, which carry the rate code (176.4 khz is 4'hc)
		if (i == 12) begin
			k = 0;
			while (q.size() < 56 && k < 20000) begin
				@(posedge clk);
				k++;
			end
			chk("status_frames", 1, q.size() >= 56);
			for (j = 48; j < 56 && q.size() >= 56; j++) begin
				x = q[j];
				chk("rate_code", (4'hc >> (j / 2 - 24)) & 1, x[26]);
			end
		end
	endtask

	initial begin
		int          i;
		logic [31:0] r;
		logic        e;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		rx0_slots = '0;
		rx1_pair = '0;
		alt_pair = '0;
		alt_toggle = 1'b0;
		fsp = 2'h0;
		ph = 2'h0;
		fcnt = 9'h000;
		fs_sel = 1'b0;
		pll_bit_tick = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		void'($urandom(25));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("tx_line", 0, tx_line);
		apb(1'b0, OFS_CTRL, 32'h0000_0000, r, e);
		chk("ctrl", 32'h0000_0009, r);
		apb(1'b0, OFS_FMT, 32'h0000_0000, r, e);
		chk("fmt", 32'h0000_0004, r);
		apb(1'b0, 8'h10, 32'h0000_0000, r, e);
		chk("slverr", 1, e);
		chk("unmapped", 0, r);
		cs = $urandom;
		apb(1'b1, OFS_CSTAT, cs, r, e);
		apb(1'b0, OFS_CSTAT, 32'h0000_0000, r, e);
		chk("cstat", cs, r);
		for (i = 0; i < 16; i++)
			run_cfg(i);
		test_done;
	end
	initial begin
		#400000;
		n_mismatch++;
		test_done;
	end
endmodule
`default_nettype wire

// ===== logic/spt_bmc_line.sv
// Purpose: line driver that turns per-cell toggle requests into the output level
// Assumes: cell_en pulses once per half-bit cell
// Notes:   forced low while powered down
`timescale 1ns/1ps
`default_nettype none
module spt_bmc_line (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic cell_en,
	input  wire logic toggle,
	input  wire logic force_low,
	output logic      line
);
	logic line_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_q <= 1'b0;
		end else if (force_low) begin
			line_q <= 1'b0; // [RULE21]
		end else if (cell_en && toggle) begin
			line_q <= ~line_q; // [RULE20]
		end
	end

	assign line = line_q;
endmodule
`default_nettype wire

// ===== logic/spt_pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes:   output follows only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module spt_pin_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pins,
	output logic      [W-1:0] synced
);
	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;
	logic [W-1:0] out_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ff1_q <= '0;
			ff2_q <= '0;
			ff3_q <= '0;
		end else begin
			ff1_q <= pins;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					out_q[i] <= 1'b0;
				end else if (ff2_q[i] == ff3_q[i]) begin
					out_q[i] <= ff3_q[i];
				end
			end
		end
	endgenerate

	assign synced = out_q;
endmodule
`default_nettype wire

// ===== logic/spt_pkg.sv
// Purpose: shared constants, register layout and types of the pass-through transmitter
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   line states are counted as half-bit cells, 128 per frame
package spt_pkg;

	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_FMT         = 8'h04;
	localparam logic [7:0]  OFS_CSTAT       = 8'h08;
	localparam logic [7:0]  OFS_STATUS      = 8'h0c;

	localparam logic [10:0] CTRL_RST        = 11'h009;
	localparam logic [13:0] FMT_RST         = 14'h0004;
	localparam logic [31:0] CSTAT_RST       = 32'h0000_0000;

	localparam logic [6:0]  HALF_LAST       = 7'h7f;
	localparam logic [7:0]  FRAME_LAST      = 8'hbf;
	localparam logic [4:0]  SLOT_AUDIO      = 5'h04;
	localparam logic [4:0]  SLOT_VALID      = 5'h1c;
	localparam int          CS_REG_BITS     = 32;

	// transition masks of the preambles, msb is the first half cell
	localparam logic [7:0]  PRE_B           = 8'h9c;
	localparam logic [7:0]  PRE_M           = 8'h93;
	localparam logic [7:0]  PRE_W           = 8'h96;

	localparam logic [1:0]  WID_16          = 2'h0;
	localparam logic [1:0]  WID_20          = 2'h1;
	localparam logic [1:0]  WID_24          = 2'h2;
	localparam logic [1:0]  WID_32          = 2'h3;

	typedef struct packed {
		logic mono;
		logic clk_src_pll;
		logic sync_pol;
		logic sync_sel;
		logic second_port_double_rate;
		logic first_port_double_rate;
		logic src_alt;
		logic global_power_down;
		logic keepalive_enable_bit;
		logic data_path_enable;
		logic transmitter_power_down;
	} spt_ctrl_t;

	typedef struct packed {
		logic [2:0] clk_div;
		logic [2:0] rate;
		logic [1:0] output_sample_width;
		logic [1:0] rx_slot_resolution;
		logic [1:0] right_slot_select;
		logic [1:0] left_slot_select;
	} spt_fmt_t;

	typedef struct packed {
		logic [31:0] left;
		logic [31:0] right;
	} spt_pair_t;

	// divider codes 0..3 divide by 1..4, every other code by 8
	function automatic logic [3:0] spt_div_factor(input logic [2:0] code);
		case (code)
			3'h0: spt_div_factor = 4'h1;
			3'h1: spt_div_factor = 4'h2;
			3'h2: spt_div_factor = 4'h3;
			3'h3: spt_div_factor = 4'h4;
			default: spt_div_factor = 4'h8;
		endcase
	endfunction

	// rate index 0..6 = 32, 44.1, 48, 88.2, 96, 176.4, 192 khz
	function automatic logic [3:0] spt_rate_code(input logic [2:0] rate);
		case (rate)
			3'h0: spt_rate_code = 4'h3;
			3'h1: spt_rate_code = 4'h0;
			3'h2: spt_rate_code = 4'h2;
			3'h3: spt_rate_code = 4'h8;
			3'h4: spt_rate_code = 4'ha;
			3'h5: spt_rate_code = 4'hc;
			3'h6: spt_rate_code = 4'he;
			default: spt_rate_code = 4'h1;
		endcase
	endfunction

	// samples are msb justified, so a width keeps the top bits
	function automatic logic [31:0] spt_width_mask(input logic [1:0] code);
		case (code)
			WID_16: spt_width_mask = 32'hffff_0000;
			WID_20: spt_width_mask = 32'hffff_f000;
			WID_24: spt_width_mask = 32'hffff_ff00;
			default: spt_width_mask = 32'hffff_ffff;
		endcase
	endfunction

endpackage

// ===== logic/spt_spdif_tx.sv
// Purpose: pass-through biphase-mark audio transmitter with apb registers
// Assumes: tdm slot words are held stable in the clk domain; alt bus words stable around their toggle
// Notes:   one sample pair is taken per frame-sync edge
// Function
// RULE1 - controller configures, powers paths, then ports
// RULE2 - shutdown paths before serial ports
// RULE3 - only native-rate streams, no null samples
// RULE4 - two samples, widths 16/20/24/32
// RULE5 - seven frame rates set in status
// RULE6 - samples forwarded unaltered, no rate conversion
// RULE7 - slot selectors map TDM slots 0-3
// RULE8 - second port double rate takes over
// RULE9 - alternate bus samples retimed into domain
// RULE10 - frame sync source and polarity selectable
// RULE11 - settings written before powering ports
// RULE12 - bit clock 128xFs from pin or PLL
// RULE13 - pin clock when converters also run
// RULE14 - divider equals clock over 128xFs
// RULE15 - divider factors only 1,2,3,4,8
// RULE16 - preambles B every 192 frames, M, W
// RULE17 - non-duplicate second subframe sets validity
// RULE18 - each subframe has 32 slots
// RULE19 - slots 4-31 biphase-mark coded
// RULE20 - symbol first state inverts, second codes bit
// RULE21 - power-down drives low, enable adds data
// RULE22 - keep-alive bit ignored, status keeps flowing
// RULE23 - slots 0-3 carry violating preamble
// RULE24 - channel status bit sequential per frame
`timescale 1ns/1ps
`default_nettype none
module spt_spdif_tx (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [127:0]      rx0_slots,
	input  wire spt_pkg::spt_pair_t rx1_pair,
	input  wire spt_pkg::spt_pair_t alt_pair,
	input  wire logic              alt_toggle,
	input  wire logic [1:0]        frame_sync_pins,
	input  wire logic              serial_clock_input_pin,
	input  wire logic              pll_bit_tick,
	output logic                   tx_line
);
	import spt_pkg::*;

	spt_ctrl_t   ctrl_q;
	spt_fmt_t    fmt_q;
	logic [31:0] cstat_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	logic [3:0]  sy;
	logic        sclk_prev_q;
	logic        fs_prev_q;
	logic        tog_prev_q;
	logic [3:0]  div_cnt_q;
	logic        running_q;
	logic [6:0]  half_q;
	logic [7:0]  frame_q;
	spt_pair_t   alt_q;
	spt_pair_t   hold_q;
	spt_pair_t   cur_q;
	spt_pair_t   sel_pair;

	logic        pd;
	logic        src_edge;
	logic        cell_en;
	logic        fs_level;
	logic        fs_edge;
	logic        alt_new;
	logic        sub;
	logic [4:0]  slot;
	logic [31:0] word;
	logic [31:0] cs_word;
	logic        cs_bit;
	logic [7:0]  pre_mask;
	logic        toggle;
	logic        apb_access;
	logic        mapped;

	// ---------------- apb slave ----------------
	assign apb_access = psel && penable && pready_q;
	assign mapped     = (paddr == OFS_CTRL) || (paddr == OFS_FMT) ||
	                    (paddr == OFS_CSTAT) || (paddr == OFS_STATUS);

	// one wait state: ready rises in the first access cycle, so the master sees it on the next edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (psel && penable && !pready_q) begin
			pready_q  <= 1'b1;
			pslverr_q <= !mapped;
			case (paddr)
				OFS_CTRL:   prdata_q <= {21'h00_0000, ctrl_q};
				OFS_FMT:    prdata_q <= {18'h0_0000, fmt_q};
				OFS_CSTAT:  prdata_q <= cstat_q;
				OFS_STATUS: prdata_q <= {15'h0000, running_q, 1'b0, half_q, frame_q};
				default:    prdata_q <= 32'h0000_0000;
			endcase
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// keepalive_enable_bit is stored for readback only; nothing below reads it [RULE22]
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q  <= spt_ctrl_t'(CTRL_RST);
			fmt_q   <= spt_fmt_t'(FMT_RST);
			cstat_q <= CSTAT_RST;
		end else if (apb_access && pwrite) begin
			case (paddr)
				OFS_CTRL:  ctrl_q  <= spt_ctrl_t'(pwdata[10:0]);
				OFS_FMT:   fmt_q   <= spt_fmt_t'(pwdata[13:0]);
				OFS_CSTAT: cstat_q <= pwdata;
				default:   ;
			endcase
		end
	end

	// ---------------- pin crossing ----------------
	spt_pin_sync #(
		.W (4)
	) u_sync (
		.clk    (clk),
		.rst_n  (rst_n),
		.pins   ({alt_toggle, serial_clock_input_pin, frame_sync_pins}),
		.synced (sy)
	);

	assign pd       = ctrl_q.transmitter_power_down || ctrl_q.global_power_down;
	assign fs_level = sy[ctrl_q.sync_sel] ^ ctrl_q.sync_pol; // [RULE10]
	assign fs_edge  = fs_level && !fs_prev_q;
	assign alt_new  = sy[3] ^ tog_prev_q;
	// the pin clock is used at clk/4 at most, so edge detection on the filtered copy is safe
	assign src_edge = ctrl_q.clk_src_pll ? pll_bit_tick : (sy[2] && !sclk_prev_q); // [RULE12]

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
			fs_prev_q   <= 1'b0;
			tog_prev_q  <= 1'b0;
		end else begin
			sclk_prev_q <= sy[2];
			fs_prev_q   <= fs_level;
			tog_prev_q  <= sy[3];
		end
	end

	// the sender keeps the words still while its toggle settles, so a plain capture is safe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alt_q <= '0;
		end else if (alt_new) begin
			alt_q <= alt_pair; // [RULE9]
		end
	end

	// ---------------- clock divider ----------------
	assign cell_en = src_edge && (div_cnt_q == spt_div_factor(fmt_q.clk_div) - 4'h1); // [RULE14] [RULE15]

	always_ff @(posedge clk) begin
		if (!rst_n || pd) begin
			div_cnt_q <= 4'h0;
		end else if (cell_en) begin
			div_cnt_q <= 4'h0;
		end else if (src_edge) begin
			div_cnt_q <= div_cnt_q + 4'h1;
		end
	end

	// ---------------- source selection ----------------
	always_comb begin
		sel_pair = '0;
		if (ctrl_q.src_alt) begin
			sel_pair = alt_q;
		end else if (ctrl_q.second_port_double_rate) begin
			sel_pair = rx1_pair; // [RULE8]
		end else begin
			sel_pair.left  = rx0_slots[32*fmt_q.left_slot_select +: 32]; // [RULE7]
			sel_pair.right = rx0_slots[32*fmt_q.right_slot_select +: 32];
		end
	end

	// one pair per frame-sync edge; null samples of a bursty stream would be sent as audio [RULE3]
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_q <= '0;
		end else if (fs_edge) begin
			hold_q <= sel_pair;
		end
	end

	// ---------------- frame engine ----------------
	always_ff @(posedge clk) begin
		if (!rst_n || pd) begin
			running_q <= 1'b0;
		end else if (fs_edge) begin
			running_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || pd || !running_q) begin
			half_q  <= 7'h00;
			frame_q <= 8'h00;
		end else if (cell_en) begin
			half_q <= half_q + 7'h01; // [RULE18]
			if (half_q == HALF_LAST) begin
				frame_q <= (frame_q == FRAME_LAST) ? 8'h00 : frame_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cur_q <= '0;
		end else if (!running_q || (cell_en && half_q == HALF_LAST)) begin
			cur_q <= hold_q; // [RULE6]
		end
	end

	assign sub  = half_q[6];
	assign slot = half_q[5:1];

	// rate code sits in status bits 24..27
	assign cs_word = {cstat_q[31:28], spt_rate_code(fmt_q.rate), cstat_q[23:0]}; // [RULE5]
	assign cs_bit  = (frame_q < 8'(CS_REG_BITS)) ? cs_word[frame_q[4:0]] : 1'b0; // [RULE24]

	always_comb begin
		logic [31:0] smp;
		logic        nodata;
		smp    = sub ? cur_q.right : cur_q.left;
		nodata = !ctrl_q.data_path_enable || (sub && ctrl_q.mono);
		word   = 32'h0000_0000;
		if (ctrl_q.mono && sub) begin
			smp = 32'h0000_0000;
		end
		smp = smp & spt_width_mask(fmt_q.output_sample_width) &
		      spt_width_mask(fmt_q.rx_slot_resolution); // [RULE4]
		if (!ctrl_q.data_path_enable) begin
			smp = 32'h0000_0000; // [RULE21]
		end
		word[27:4] = smp[31:8];
		word[28]   = nodata; // [RULE17]
		word[30]   = cs_bit; // [RULE22]
		word[31]   = ^word[30:4];
	end

	always_comb begin
		if (sub) begin
			pre_mask = PRE_W;
		end else if (frame_q == 8'h00) begin
			pre_mask = PRE_B; // [RULE16]
		end else begin
			pre_mask = PRE_M;
		end
	end

	// preamble cells follow a fixed mask that breaks the coding [RULE23]
	assign toggle = (slot < SLOT_AUDIO) ? pre_mask[3'h7 - half_q[2:0]] :
	                (!half_q[0] ? 1'b1 : word[slot]); // [RULE19] [RULE20]

	spt_bmc_line u_line (
		.clk       (clk),
		.rst_n     (rst_n),
		.cell_en   (cell_en && running_q),
		.toggle    (toggle),
		.force_low (pd),
		.line      (tx_line)
	);

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ---------------- checks ----------------
	chk_pd_line_low: assert property (@(posedge clk) disable iff (!rst_n) // [RULE21]
		pd |=> !tx_line)
		else $error("line not low in power down");

	chk_half_wrap: assert property (@(posedge clk) disable iff (!rst_n || pd) // [RULE18]
		(running_q && cell_en && half_q == HALF_LAST) |=> (half_q == 7'h00))
		else $error("subframe counter did not wrap");

	chk_block_wrap: assert property (@(posedge clk) disable iff (!rst_n || pd) // [RULE16]
		(running_q && cell_en && half_q == HALF_LAST && frame_q == FRAME_LAST) |=> (frame_q == 8'h00))
		else $error("block did not restart after 192 frames");

	chk_div_one: assert property (@(posedge clk) disable iff (!rst_n || pd) // [RULE15]
		(fmt_q.clk_div == 3'h0 && src_edge) |-> cell_en)
		else $error("divide by one missed a cell");

	chk_line_toggle: assert property (@(posedge clk) disable iff (!rst_n || pd) // [RULE20]
		(running_q && cell_en && toggle) |=> (tx_line != $past(tx_line)))
		else $error("line did not change on requested toggle");

	chk_first_cell: assert property (@(posedge clk) disable iff (!rst_n || pd) // [RULE19]
		(running_q && cell_en && slot >= SLOT_AUDIO && !half_q[0]) |=> (tx_line != $past(tx_line)))
		else $error("data symbol lacks opening transition");

	chk_mono_valid: assert property (@(posedge clk) disable iff (!rst_n) // [RULE17]
		(ctrl_q.mono && sub) |-> word[SLOT_VALID])
		else $error("validity not set on empty second subframe");

	chk_even_parity: assert property (@(posedge clk) disable iff (!rst_n) // [RULE19]
		(^word[31:4]) == 1'b0)
		else $error("subframe parity odd");

	chk_second_port: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
		(!ctrl_q.src_alt && ctrl_q.second_port_double_rate) |-> (sel_pair == rx1_pair))
		else $error("second port not selected");

	chk_apb_ready: assert property (@(posedge clk) disable iff (!rst_n)
		(psel && penable && !pready_q) |=> (pready_q ##1 !pready_q))
		else $error("apb answer not one cycle");
endmodule
`default_nettype wire
